// ===== rtl/acc_unit_pkg.sv
// constants shared by the accumulator xor and compare unit
package acc_unit_pkg;

	// ==========================================================
	// sizes
	localparam int DATA_W = 32;
	localparam int HALF_W = 16;
	localparam int STACK_DEPTH = 8;
	localparam int WMEM_WORDS = 64;
	localparam int BIT_COUNT = 256;
	localparam int BIT_WORDS = 8;
	localparam int IDX_W = 7;

	// ==========================================================
	// register byte offsets
	localparam logic [11:0] OFS_ACC = 12'h000;
	localparam logic [11:0] OFS_PUSH = 12'h004;
	localparam logic [11:0] OFS_DEPTH = 12'h008;
	localparam logic [11:0] OFS_CMD = 12'h00C;
	localparam logic [11:0] OFS_CONST = 12'h010;
	localparam logic [11:0] OFS_FLAGS = 12'h014;
	localparam logic [11:0] OFS_BITS = 12'h080;
	localparam logic [11:0] OFS_WMEM = 12'h100;

	// ==========================================================
	// command word fields
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_OP_W = 3;
	localparam int CMD_IND_BIT = 3;
	localparam int CMD_K_BIT = 4;
	localparam int CMD_ADDR_LSB = 5;
	localparam int CMD_ADDR_W = 8;
	localparam int CMD_LEN_LSB = 13;
	localparam int CMD_LEN_W = 5;

	// ==========================================================
	// operation codes
	localparam logic [2:0] OP_FXOR = 3'h1;
	localparam logic [2:0] OP_SXOR = 3'h2;
	localparam logic [2:0] OP_CMP = 3'h3;
	localparam logic [2:0] OP_DOUBLE_WORD_COMPARE = 3'h4;

	// ==========================================================
	// flag bit positions and reset values
	localparam int FLG_LT = 0;
	localparam int FLG_EQ = 1;
	localparam int FLG_GT = 2;
	localparam int FLG_ZERO = 3;
	localparam int FLG_NEG = 4;
	localparam int FLG_W = 5;
	localparam logic [31:0] ACC_RST = 32'h0000_0000;
	localparam logic [31:0] CONST_RST = 32'h0000_0000;
	localparam logic [4:0] FLAGS_RST = 5'h00;
	localparam logic [3:0] DEPTH_RST = 4'h0;

endpackage

// ===== rtl/bit_group_extract.sv
// picks a run of discrete bits and right-aligns it
`timescale 1ns/1ns
`default_nettype none
module bit_group_extract (
	input wire logic [acc_unit_pkg::BIT_COUNT-1:0] bits,
	input wire logic [acc_unit_pkg::CMD_ADDR_W-1:0] start,
	input wire logic [acc_unit_pkg::CMD_LEN_W-1:0] len_m1,
	output logic [acc_unit_pkg::DATA_W-1:0] group
);
	import acc_unit_pkg::*;

	logic [BIT_COUNT+DATA_W-1:0] shifted;
	logic [DATA_W-1:0] mask;

	// ==========================================================
	// first bit lands at bit zero, bits past the length read zero
	always_comb begin
		shifted = {{DATA_W{1'b0}}, bits} >> start;
		mask = {DATA_W{1'b1}} >> (5'h1F - len_m1);
		group = shifted[DATA_W-1:0] & mask;
	end
endmodule // bit_group_extract
`default_nettype wire

// ===== rtl/magnitude_compare.sv
// unsigned three-way compare
`timescale 1ns/1ns
`default_nettype none
module magnitude_compare (
	input wire logic [acc_unit_pkg::DATA_W-1:0] a,
	input wire logic [acc_unit_pkg::DATA_W-1:0] b,
	output logic less,
	output logic equal,
	output logic greater
);
	import acc_unit_pkg::*;

	// ==========================================================
	// exactly one output is high
	always_comb begin
		less = a < b;
		equal = a == b;
		greater = a > b;
	end
endmodule // magnitude_compare
`default_nettype wire

// ===== rtl/accumulator_xor_compare_unit.sv
// accumulator xor and compare datapath with ahb-lite registers
//
// The register offsets and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module accumulator_xor_compare_unit (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	output logic less_than_flag,
	output logic equal_flag,
	output logic greater_than_flag,
	output logic zero_result_flag,
	output logic negative_result_flag
);
	import acc_unit_pkg::*;

	// ==========================================================
	// address decode helpers
	function automatic logic [IDX_W-1:0] word_index(input logic [11:0] ofs);
		word_index = ofs[IDX_W+1:2];
	endfunction

	function automatic logic mapped(input logic [31:0] a);
		mapped = (a[31:IDX_W+2] == '0);
	endfunction

	localparam logic [IDX_W-1:0] IDX_ACC = word_index(OFS_ACC);
	localparam logic [IDX_W-1:0] IDX_PUSH = word_index(OFS_PUSH);
	localparam logic [IDX_W-1:0] IDX_DEPTH = word_index(OFS_DEPTH);
	localparam logic [IDX_W-1:0] IDX_CMD = word_index(OFS_CMD);
	localparam logic [IDX_W-1:0] IDX_CONST = word_index(OFS_CONST);
	localparam logic [IDX_W-1:0] IDX_FLAGS = word_index(OFS_FLAGS);
	localparam logic [IDX_W-1:0] IDX_BITS = word_index(OFS_BITS);
	localparam logic [IDX_W-1:0] IDX_WMEM = word_index(OFS_WMEM);

	function automatic logic in_wmem(input logic [IDX_W-1:0] idx);
		in_wmem = (idx >= IDX_WMEM);
	endfunction

	function automatic logic in_bits(input logic [IDX_W-1:0] idx);
		in_bits = (idx >= IDX_BITS) && (idx < IDX_BITS + 7'(BIT_WORDS));
	endfunction

	// ==========================================================
	// state
	logic [DATA_W-1:0] acc_q;
	logic [DATA_W-1:0] const_q;
	logic [DATA_W-1:0] stack_q [STACK_DEPTH];
	logic [3:0] depth_q;
	logic [HALF_W-1:0] wmem_q [WMEM_WORDS];
	logic [DATA_W-1:0] bmem_q [BIT_WORDS];
	logic [FLG_W-1:0] flags_q;

	// bus pipeline
	logic wr_q;
	logic wr_ok_q;
	logic [IDX_W-1:0] widx_q;
	logic rd_wait_q;
	logic rd_ok_q;
	logic [IDX_W-1:0] ridx_q;
	logic [31:0] hrdata_q;
	logic addr_phase;
	logic wr_en;

	// ==========================================================
	// command decode
	logic cmd_exec;
	logic xor_exec;
	logic [CMD_OP_W-1:0] cmd_op;
	logic cmd_ind;
	logic cmd_k;
	logic [CMD_ADDR_W-1:0] cmd_addr;
	logic [CMD_LEN_W-1:0] cmd_len_m1;
	logic [5:0] eff_addr;
	logic [5:0] eff_addr_hi;
	logic [DATA_W-1:0] group;
	logic [DATA_W-1:0] xor_res;
	logic [DATA_W-1:0] cmp_a;
	logic [DATA_W-1:0] cmp_b;
	logic cmp_lt;
	logic cmp_eq;
	logic cmp_gt;
	logic [BIT_COUNT-1:0] bits_flat;

	// ==========================================================
	// command strobes
	assign cmd_exec = wr_en && (widx_q == IDX_CMD);
	assign xor_exec = cmd_exec &&
		(cmd_op == OP_FXOR || cmd_op == OP_SXOR);
	assign cmd_op = hwdata[CMD_OP_LSB +: CMD_OP_W];
	assign cmd_ind = hwdata[CMD_IND_BIT];
	assign cmd_k = hwdata[CMD_K_BIT];
	assign cmd_addr = hwdata[CMD_ADDR_LSB +: CMD_ADDR_W];
	assign cmd_len_m1 = hwdata[CMD_LEN_LSB +: CMD_LEN_W];

	// ==========================================================
	// discrete bits seen as one vector
	always_comb begin
		for (int i = 0; i < BIT_WORDS; i++) begin
			bits_flat[i*DATA_W +: DATA_W] = bmem_q[i];
		end
	end

	// ==========================================================
	// operand fetch
	always_comb begin
		if (cmd_ind) begin
			eff_addr = wmem_q[cmd_addr[5:0]][5:0];
		end else begin
			eff_addr = cmd_addr[5:0];
		end
		eff_addr_hi = 6'(eff_addr + 6'h01);
	end

	bit_group_extract u_extract (
		.bits(bits_flat),
		.start(cmd_addr),
		.len_m1(cmd_len_m1),
		.group(group)
	);

	// ==========================================================
	// xor result
	always_comb begin
		if (cmd_op == OP_SXOR) begin
			xor_res = acc_q ^ stack_q[0];
		end else begin
			xor_res = acc_q ^ group;
		end
	end

	// ==========================================================
	// compare operands, zero-extended for the single compare
	always_comb begin
		if (cmd_op == OP_DOUBLE_WORD_COMPARE) begin
			cmp_a = acc_q;
			if (cmd_k) begin
				cmp_b = const_q;
			end else begin
				cmp_b = {wmem_q[eff_addr_hi], wmem_q[eff_addr]};
			end
		end else begin
			cmp_a = {{HALF_W{1'b0}}, acc_q[HALF_W-1:0]};
			cmp_b = {{HALF_W{1'b0}}, wmem_q[eff_addr]};
		end
	end

	magnitude_compare u_compare (
		.a(cmp_a),
		.b(cmp_b),
		.less(cmp_lt),
		.equal(cmp_eq),
		.greater(cmp_gt)
	);

	// ==========================================================
	// accumulator
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			acc_q <= ACC_RST;
		end else if (xor_exec) begin
			acc_q <= xor_res;
		end else if (wr_en && widx_q == IDX_ACC) begin
			acc_q <= hwdata;
		end
	end

	// ==========================================================
	// accumulator stack, compares do not touch it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				stack_q[i] <= '0;
			end
			depth_q <= DEPTH_RST;
		end else if (cmd_exec && cmd_op == OP_SXOR) begin
			for (int i = 0; i < STACK_DEPTH - 1; i++) begin
				stack_q[i] <= stack_q[i+1];
			end
			stack_q[STACK_DEPTH-1] <= '0;
			if (depth_q != 4'h0) begin
				depth_q <= 4'(depth_q - 4'h1);
			end
		end else if (wr_en && widx_q == IDX_PUSH) begin
			for (int i = 1; i < STACK_DEPTH; i++) begin
				stack_q[i] <= stack_q[i-1];
			end
			stack_q[0] <= hwdata;
			if (depth_q != 4'(STACK_DEPTH)) begin
				depth_q <= 4'(depth_q + 4'h1);
			end
		end
	end

	// ==========================================================
	// constant operand
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			const_q <= CONST_RST;
		end else if (wr_en && widx_q == IDX_CONST) begin
			const_q <= hwdata;
		end
	end

	// ==========================================================
	// status flags, each held until an operation drives it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			flags_q <= FLAGS_RST;
		end else if (cmd_exec) begin
			unique case (cmd_op)
				OP_FXOR, OP_SXOR: begin
					flags_q[FLG_ZERO] <= (xor_res == '0);
					flags_q[FLG_NEG] <= xor_res[DATA_W-1];
				end
				OP_CMP, OP_DOUBLE_WORD_COMPARE: begin
					flags_q[FLG_LT] <= cmp_lt;
					flags_q[FLG_EQ] <= cmp_eq;
					flags_q[FLG_GT] <= cmp_gt;
				end
				default: begin
					flags_q <= flags_q;
				end
			endcase
		end
	end

	// ==========================================================
	// flag outputs
	assign less_than_flag = flags_q[FLG_LT];
	assign equal_flag = flags_q[FLG_EQ];
	assign greater_than_flag = flags_q[FLG_GT];
	assign zero_result_flag = flags_q[FLG_ZERO];
	assign negative_result_flag = flags_q[FLG_NEG];

	// ==========================================================
	// word memory, 16 bits per word
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < WMEM_WORDS; i++) begin
				wmem_q[i] <= '0;
			end
		end else if (wr_en && in_wmem(widx_q)) begin
			wmem_q[widx_q[5:0]] <= hwdata[HALF_W-1:0];
		end
	end

	// ==========================================================
	// discrete bit memory
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < BIT_WORDS; i++) begin
				bmem_q[i] <= '0;
			end
		end else if (wr_en && in_bits(widx_q)) begin
			bmem_q[widx_q[2:0]] <= hwdata;
		end
	end

	// ==========================================================
	// ahb-lite address phase capture
	assign addr_phase = hsel && htrans[1] && hready;
	assign wr_en = wr_q && wr_ok_q;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wr_ok_q <= 1'b0;
			widx_q <= '0;
		end else begin
			wr_q <= addr_phase && hwrite;
			wr_ok_q <= mapped(haddr);
			widx_q <= haddr[IDX_W+1:2];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_wait_q <= 1'b0;
			rd_ok_q <= 1'b0;
			ridx_q <= '0;
		end else if (rd_wait_q) begin
			rd_wait_q <= 1'b0;
		end else begin
			rd_wait_q <= addr_phase && !hwrite;
			rd_ok_q <= mapped(haddr);
			ridx_q <= haddr[IDX_W+1:2];
		end
	end

	// ==========================================================
	// read data, loaded during the single wait cycle
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata_q <= '0;
		end else if (rd_wait_q) begin
			hrdata_q <= '0;
			if (rd_ok_q) begin
				if (in_wmem(ridx_q)) begin
					hrdata_q <= {16'h0000, wmem_q[ridx_q[5:0]]};
				end else if (in_bits(ridx_q)) begin
					hrdata_q <= bmem_q[ridx_q[2:0]];
				end else if (ridx_q == IDX_ACC) begin
					hrdata_q <= acc_q;
				end else if (ridx_q == IDX_PUSH) begin
					hrdata_q <= stack_q[0];
				end else if (ridx_q == IDX_DEPTH) begin
					hrdata_q <= {28'h0000000, depth_q};
				end else if (ridx_q == IDX_CONST) begin
					hrdata_q <= const_q;
				end else if (ridx_q == IDX_FLAGS) begin
					hrdata_q <= {27'h0000000, flags_q};
				end
			end
		end
	end

	// ==========================================================
	// bus response, one wait state on reads
	assign hrdata = hrdata_q;
	assign hreadyout = !rd_wait_q;
	assign hresp = 1'b0;

endmodule // accumulator_xor_compare_unit
`default_nettype wire

// ===== bench/acc_unit_assertions.sv
// concurrent checks on the unit's bus and flag ports
`timescale 1ns/1ns
`default_nettype none
module acc_unit_assertions (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic less_than_flag,
	input wire logic equal_flag,
	input wire logic greater_than_flag,
	input wire logic zero_result_flag,
	input wire logic negative_result_flag
);
	// ==========================================================
	// helpers
	logic taken;
	logic wr_dp_q;
	logic wr_dp2_q;
	logic [2:0] cmp3;
	logic [4:0] flag_vec;
	assign taken = hsel && htrans[1] && hready;
	assign cmp3 = {less_than_flag, equal_flag, greater_than_flag};
	assign flag_vec = {cmp3, zero_result_flag, negative_result_flag};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_dp_q <= 1'b0;
			wr_dp2_q <= 1'b0;
		end else begin
			wr_dp_q <= taken && hwrite;
			wr_dp2_q <= wr_dp_q;
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence s_rd_req;
		taken && !hwrite;
	endsequence
	sequence s_rd_ans;
		!hreadyout ##1 hreadyout;
	endsequence
	// ==========================================================
	// properties
	a_read_wait: assert property (s_rd_req |=> s_rd_ans)
		else $error("read wait wrong");
	a_write_nowait: assert property (taken && hwrite |=> hreadyout)
		else $error("write stalled");
	a_ready_cause: assert property (!hreadyout |-> $past(taken && !hwrite))
		else $error("stall without read");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bad response");
	a_cmp_onehot: assert property ($onehot0(cmp3))
		else $error("compare flags clash");
	a_cmp_stays: assert property (|cmp3 |=> $onehot(cmp3))
		else $error("compare flags lost");
	a_zero_neg: assert property (!(zero_result_flag &&
		negative_result_flag))
		else $error("zero and negative both set");
	a_flags_hold: assert property ($changed(flag_vec) |-> wr_dp2_q)
		else $error("flag moved without command");
endmodule // acc_unit_assertions
bind accumulator_xor_compare_unit acc_unit_assertions i_chk (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
	.hready(hready), .hreadyout(hreadyout), .hresp(hresp),
	.less_than_flag(less_than_flag), .equal_flag(equal_flag),
	.greater_than_flag(greater_than_flag),
	.zero_result_flag(zero_result_flag),
	.negative_result_flag(negative_result_flag));
`default_nettype wire

// ===== bench/accumulator_xor_compare_unit_tb_top.sv
// self-checking bench for the accumulator xor and compare unit
`timescale 1ns/1ns
`default_nettype none
module accumulator_xor_compare_unit_tb_top;
	import acc_unit_pkg::*;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic hready, hreadyout, hresp, lt, eq, gt, zf, nf;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	int err_total = 0, n_tests = 0;
	assign hready = hreadyout;
	accumulator_xor_compare_unit i_dut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.less_than_flag(lt), .equal_flag(eq), .greater_than_flag(gt),
		.zero_result_flag(zf), .negative_result_flag(nf));
	initial forever #25 hclk = ~hclk;
	// ==========================================================
	// shared tasks
	task chk(string s, logic [31:0] g, logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s exp %h got %h", s, e, g);
		end
	endtask
	task bus(logic w, logic [11:0] a, logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {20'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		r = hrdata;
	endtask
	task wr(logic [11:0] a, logic [31:0] d);
		bus(1'b1, a, d);
	endtask
	task rd(logic [11:0] a, logic [31:0] e, string s);
		bus(1'b0, a, 32'h0);
		chk(s, r, e);
	endtask
	task flg(logic [4:0] e);
		rd(OFS_FLAGS, {27'h0, e}, "flags");
		chk("flag pins", {27'h0, nf, zf, gt, eq, lt}, {27'h0, e});
	endtask
	function logic [31:0] cmd(logic [2:0] o, logic i, logic k,
		logic [7:0] a, logic [4:0] m);
		return {14'h0, m, a, k, i, o};
	endfunction
	task summarize;
		$display("tests %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task t_reset;
		rd(OFS_ACC, ACC_RST, "acc");
		rd(OFS_DEPTH, 32'h0, "depth");
		rd(OFS_CONST, CONST_RST, "const");
		flg(FLAGS_RST);
		wr(12'h200, 32'hFFFFFFFF);
		rd(12'h200, 32'h0, "unmapped");
		wr(OFS_CONST, 32'hFFFFFFFF);
		rd(OFS_CONST, 32'hFFFFFFFF, "const");
		$display("reset test done");
	endtask
	task automatic t_fxor;
		logic [31:0] ac[3] = '{32'hFFFF0000, 32'hC0000001, 32'h0};
		logic [31:0] ex[3] = '{32'hFFFF0007, 32'h0, 32'h1};
		logic [7:0] st[3] = '{8'h1E, 8'h00, 8'hFF};
		logic [4:0] ln[3] = '{5'h03, 5'h1F, 5'h1F};
		logic [4:0] fl[3] = '{5'h10, 5'h08, 5'h00};
		wr(OFS_BITS, 32'hC0000001);
		wr(OFS_BITS + 12'h4, 32'h5);
		wr(OFS_BITS + 12'h1C, 32'h80000000);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_ACC, ac[i]);
			wr(OFS_CMD, cmd(OP_FXOR, 1'b0, 1'b0, st[i], ln[i]));
			rd(OFS_ACC, ex[i], "xor acc");
			flg(fl[i]);
		end
		$display("formatted xor test done");
	endtask
	task automatic t_cmp;
		logic [31:0] ac[3] = '{32'hABCD1234, 32'h1233, 32'hFFFF1235};
		logic [7:0] ad[3] = '{8'h05, 8'h07, 8'h05};
		logic [4:0] fl[3] = '{5'h02, 5'h01, 5'h04};
		wr(OFS_WMEM + 12'h14, 32'hFFFF1234);
		rd(OFS_WMEM + 12'h14, 32'h1234, "word");
		wr(OFS_WMEM + 12'h1C, 32'h5);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_ACC, ac[i]);
			wr(OFS_CMD, cmd(OP_CMP, i == 1, 1'b0, ad[i], 5'h0));
			flg(fl[i]);
			rd(OFS_ACC, ac[i], "cmp acc");
		end
		$display("single compare test done");
	endtask
	task automatic t_double_word_compare;
		logic [31:0] ac[5] = '{32'h12345679, 32'h1FFFF, 32'h12345677,
			32'hFFFFFFFF, 32'h12345679};
		logic [7:0] ad[5] = '{8'h0A, 8'h3F, 8'h07, 8'h00, 8'h00};
		logic [4:0] fl[5] = '{5'h04, 5'h02, 5'h01, 5'h02, 5'h01};
		wr(OFS_WMEM + 12'h28, 32'h5678);
		wr(OFS_WMEM + 12'h2C, 32'h1234);
		wr(OFS_WMEM + 12'hFC, 32'hFFFF);
		wr(OFS_WMEM, 32'h1);
		wr(OFS_WMEM + 12'h1C, 32'hA);
		for (int i = 0; i < 5; i++) begin
			wr(OFS_ACC, ac[i]);
			wr(OFS_CMD, cmd(OP_DOUBLE_WORD_COMPARE, i == 2, i > 2, ad[i], 5'h0));
			flg(fl[i]);
			rd(OFS_DEPTH, 32'h0, "cmp depth");
		end
		$display("double compare test done");
	endtask
	task t_sxor;
		wr(OFS_PUSH, 32'h11110000);
		wr(OFS_PUSH, 32'h800000FF);
		rd(OFS_DEPTH, 32'h2, "depth");
		wr(OFS_ACC, 32'hFF);
		wr(OFS_CMD, cmd(OP_CMP, 1'b0, 1'b0, 8'h00, 5'h00));
		flg(5'h04);
		rd(OFS_DEPTH, 32'h2, "cmp depth");
		rd(OFS_PUSH, 32'h800000FF, "cmp level0");
		rd(OFS_ACC, 32'hFF, "cmp acc");
		wr(OFS_CMD, cmd(OP_SXOR, 1'b0, 1'b0, 8'h0, 5'h0));
		rd(OFS_ACC, 32'h80000000, "sxor acc");
		rd(OFS_DEPTH, 32'h1, "depth");
		rd(OFS_PUSH, 32'h11110000, "level0");
		flg(5'h14);
		wr(OFS_CMD, cmd(OP_SXOR, 1'b0, 1'b0, 8'h0, 5'h0));
		rd(OFS_ACC, 32'h91110000, "sxor acc");
		rd(OFS_DEPTH, 32'h0, "depth");
		wr(OFS_ACC, 32'h0);
		wr(OFS_PUSH, 32'h0);
		wr(OFS_CMD, cmd(OP_SXOR, 1'b0, 1'b0, 8'h0, 5'h0));
		flg(5'h0C);
		wr(OFS_CMD, cmd(3'h5, 1'b0, 1'b0, 8'h00, 5'h00));
		wr(OFS_CMD, cmd(3'h0, 1'b0, 1'b0, 8'h00, 5'h00));
		flg(5'h0C);
		rd(OFS_ACC, 32'h0, "noop acc");
		rd(OFS_CMD, 32'h0, "cmd read");
		$display("stack xor test done");
	endtask
	// ==========================================================
	// main sequence and watchdog
	initial begin
		#100000;
		err_total++;
		summarize;
	end
	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset;
		t_fxor;
		t_cmp;
		t_double_word_compare;
		t_sxor;
		summarize;
	end
endmodule // accumulator_xor_compare_unit_tb_top
`default_nettype wire
